// [rtl/sds_pkg.sv]
// shared constants of the sleep and status register block
package sds_pkg;
   // ----------------------------------------------------------------
   // register word addresses
   // ----------------------------------------------------------------
   localparam logic [6:0]  ADDR_SLEEP      = 7'h24;
   localparam logic [6:0]  ADDR_FLAGS      = 7'h26;
   localparam logic [6:0]  ADDR_LOT_FIRST  = 7'h32;
   localparam logic [6:0]  ADDR_LOT_SECOND = 7'h34;
   localparam logic [6:0]  ADDR_LOT_THIRD  = 7'h36;
   localparam logic [6:0]  ADDR_PRODUCT    = 7'h38;
   localparam logic [6:0]  ADDR_SERIAL     = 7'h3a;
   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int          WORD_BITS       = 16;
   localparam int          SERIAL_BITS     = 14;
   localparam int          CMD_WRITE_BIT   = 15;
   localparam logic [7:0]  SLEEP_FOREVER   = 8'hff;
   localparam logic [7:0]  SLEEP_NONE      = 8'h00;
   localparam logic [7:0]  SLEEP_RESET     = 8'h00;
   localparam logic [15:0] FLAGS_RESET     = 16'h0000;
   localparam logic [15:0] FLAGS_USED      = 16'h037d;
   localparam int          F_SUPPLY        = 0;
   localparam int          F_FLASH         = 2;
   localparam int          F_SPI           = 3;
   localparam int          F_RANGE         = 4;
   localparam int          F_SELF          = 5;
   localparam int          F_CSUM          = 6;
   localparam int          F_ALM1          = 8;
   localparam int          F_ALM2          = 9;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam longint      CLK_PERIOD_PS   = 4000;
   localparam longint      SLEEP_LSB_MS    = 500;
   localparam longint      SLEEP_LSB_CYC   = SLEEP_LSB_MS * 64'd1000000000 / CLK_PERIOD_PS;
endpackage : sds_pkg

// [rtl/sds_word_if.sv]
// word carrier between the serial link and the register core
`timescale 1ns/10ps
interface sds_word_if;
   logic [15:0] rx_word;
   logic        rx_toggle;
   logic        partial;
   logic [15:0] tx_word;
   modport link (output rx_word, output rx_toggle, output partial, input tx_word);
   modport core (input rx_word, input rx_toggle, input partial, output tx_word);
endinterface : sds_word_if

// [rtl/sds_sync.sv]
// two-flop level synchroniser, one bit per lane
`timescale 1ns/10ps
module sds_sync
#(
   parameter int         W     = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_d,
   output      logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } sync_t;

   sync_t st;
   sync_t next_st;

   always_comb
   begin
      next_st.meta = i_d;
      next_st.q    = st.meta;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st <= '{meta: INIT, q: INIT};
      else
         st <= next_st;
   end

   assign o_q = st.q;
endmodule : sds_sync

// [rtl/sds_spi_link.sv]
// serial link end: shifts 16-bit words in and out on the host clock
`timescale 1ns/10ps
module sds_spi_link
(
   input  wire logic i_rst_n,
   input  wire logic i_sclk,
   input  wire logic i_cs_n,
   input  wire logic i_mosi,
   output      logic o_miso,
   output      logic o_miso_oe,
   sds_word_if.link  bus
);
   typedef struct packed {
      logic [3:0]  cnt;
      logic [15:0] sh;
      logic [15:0] word;
      logic        tog;
      logic        part;
   } rx_t;

   rx_t  rx;
   rx_t  next_rx;
   logic in_frame;
   logic next_miso;

   // the clock only runs inside frames, so the frame flag is cleared by
   // chip select itself; the edge count survives so the core can judge it
   always_ff @(posedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
         in_frame <= 1'b0;
      else
         in_frame <= 1'b1;
   end

   always_comb
   begin
      next_rx     = rx;
      next_rx.sh  = {rx.sh[14:0], i_mosi};
      next_rx.cnt = in_frame ? rx.cnt + 4'h1 : 4'h1;
      if (in_frame && rx.cnt == 4'hf)
      begin
         next_rx.word = {rx.sh[14:0], i_mosi};
         next_rx.tog  = !rx.tog;
      end
      next_rx.part = next_rx.cnt != 4'h0;
   end

   always_ff @(posedge i_sclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rx <= '{cnt: 4'h0, sh: 16'h0000, word: 16'h0000, tog: 1'b0, part: 1'b0};
      else
         rx <= next_rx;
   end

   // the core refreshes the answer within a few core cycles of a word,
   // well inside half a link period
   assign next_miso = bus.tx_word[4'hf - (in_frame ? rx.cnt : 4'h0)];

   always_ff @(negedge i_sclk or posedge i_cs_n)
   begin
      if (i_cs_n)
      begin
         o_miso    <= 1'b0;
         o_miso_oe <= 1'b0;
      end
      else
      begin
         o_miso    <= next_miso;
         o_miso_oe <= 1'b1;
      end
   end

   assign bus.rx_word   = rx.word;
   assign bus.rx_toggle = rx.tog;
   assign bus.partial   = rx.part;
endmodule : sds_spi_link

// [rtl/sleep_and_diagnostic_status.sv]
// sleep control, clear-on-read error flags and identity registers
`timescale 1ns/10ps

// Summary of operation
// - low byte all ones: sleep until woken
// - chip select fall or reset pulse wakes
// - values 0..254 sleep value times half second
// - each flag reads one while error seen
// - reading flags returns them, then clears all
// - persisting error sets again next sample
// - supply low flag clears itself when restored
// - frame not multiple of sixteen sets flag
// - bits nine and eight follow both alarms
// - bit six reports checksum mismatch
// - bit five reports self-test failure
// - bit four reports measurement over range
// - bit two reports failed flash update
// - flags reset zero, unused bits stay zero
// - serial number in low fourteen bits
// - three lot registers return sixteen bits
// - product register returns fixed code
// - self-test completion writes result flag
module sleep_and_diagnostic_status
#(
   parameter logic [31:0]  HALF_SEC_CYCLES = 32'(sds_pkg::SLEEP_LSB_CYC),
   parameter logic [15:0]  LOT_FIRST       = 16'h0001,
   parameter logic [15:0]  LOT_SECOND      = 16'h0002,
   parameter logic [15:0]  LOT_THIRD       = 16'h0003,
   parameter logic [13:0]  SERIAL_NUMBER   = 14'h0001,
   // value is arbitrary
   parameter logic [15:0]  PRODUCT_CODE    = 16'h1234
)
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_sclk,
   input  wire logic i_cs_n,
   input  wire logic i_mosi,
   output      logic o_miso,
   output      logic o_miso_oe,
   input  wire logic i_sample_tick,
   input  wire logic i_supply_low,
   input  wire logic i_flash_fail,
   input  wire logic i_over_range,
   input  wire logic i_checksum_fail,
   input  wire logic i_alarm_first,
   input  wire logic i_alarm_second,
   input  wire logic i_selftest_done,
   input  wire logic i_selftest_fail,
   output      logic o_sample_run
);
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {ST_AWAKE, ST_TIMED, ST_HOLD} pwr_t;

   typedef struct packed {
      pwr_t        pwr;
      logic        run;
      logic [7:0]  sleep;
      logic [31:0] sub;
      logic [7:0]  halves;
      logic [15:0] flags;
      logic [15:0] tx;
      logic        cs_q;
      logic        tog_q;
   } state_t;

   state_t st;
   state_t next_st;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function automatic logic [15:0] one_bit(input int pos, input logic v);
      logic [15:0] r;
      r      = 16'h0000;
      r[pos] = v;
      return r;
   endfunction : one_bit

   function automatic logic [6:0] word_addr(input logic [6:0] a);
      return {a[6:1], 1'b0};
   endfunction : word_addr

   function automatic logic [15:0] reg_read(input logic [6:0] a,
                                            input logic [15:0] flags,
                                            input logic [7:0] sleep);
      logic [15:0] r;
      r = 16'h0000;
      unique case (word_addr(a))
         sds_pkg::ADDR_SLEEP:      r = {8'h00, sleep};
         sds_pkg::ADDR_FLAGS:      r = flags;
         sds_pkg::ADDR_LOT_FIRST:  r = LOT_FIRST;
         sds_pkg::ADDR_LOT_SECOND: r = LOT_SECOND;
         sds_pkg::ADDR_LOT_THIRD:  r = LOT_THIRD;
         sds_pkg::ADDR_PRODUCT:    r = PRODUCT_CODE;
         sds_pkg::ADDR_SERIAL:     r = {2'b00, SERIAL_NUMBER};
         default:                  r = 16'h0000;
      endcase
      return r;
   endfunction : reg_read

   // ----------------------------------------------------------------
   // link and crossings
   // ----------------------------------------------------------------
   sds_word_if wbus ();

   sds_spi_link u_link
   (
      .i_rst_n   (i_rst_n),
      .i_sclk    (i_sclk),
      .i_cs_n    (i_cs_n),
      .i_mosi    (i_mosi),
      .o_miso    (o_miso),
      .o_miso_oe (o_miso_oe),
      .bus       (wbus.link)
   );

   logic [2:0] sync_q;

   sds_sync #(.W(3), .INIT(3'b001)) u_sync
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_d     ({wbus.partial, wbus.rx_toggle, i_cs_n}),
      .o_q     (sync_q)
   );

   logic        cs_s;
   logic        tog_s;
   logic        part_s;
   logic        word_ev;
   logic        cs_fall;
   logic        cs_rise;
   logic        is_wr;
   logic        is_rd;
   logic [6:0]  addr;
   logic [7:0]  data;
   logic        wr_sleep;
   logic        rd_flags;
   logic        frame_err;
   logic        tick;
   logic [15:0] cond;
   logic [15:0] sets;
   logic [15:0] clrs;

   assign cs_s      = sync_q[0];
   assign tog_s     = sync_q[1];
   assign part_s    = sync_q[2];
   // word is stable long before its toggle arrives here
   assign word_ev   = tog_s ^ st.tog_q;
   assign cs_fall   = st.cs_q && !cs_s;
   assign cs_rise   = !st.cs_q && cs_s;
   assign addr      = wbus.rx_word[14:8];
   assign data      = wbus.rx_word[7:0];
   assign is_wr     = word_ev && wbus.rx_word[sds_pkg::CMD_WRITE_BIT];
   assign is_rd     = word_ev && !wbus.rx_word[sds_pkg::CMD_WRITE_BIT];
   assign wr_sleep  = is_wr && addr == sds_pkg::ADDR_SLEEP;
   assign rd_flags  = is_rd && word_addr(addr) == sds_pkg::ADDR_FLAGS;
   assign frame_err = cs_rise && part_s;
   // sampling is suspended while asleep
   assign tick      = i_sample_tick && st.run;

   // ----------------------------------------------------------------
   // flag sources
   // ----------------------------------------------------------------
   assign cond = one_bit(sds_pkg::F_SUPPLY, i_supply_low)
               | one_bit(sds_pkg::F_FLASH, i_flash_fail)
               | one_bit(sds_pkg::F_RANGE, i_over_range)
               | one_bit(sds_pkg::F_CSUM, i_checksum_fail)
               | one_bit(sds_pkg::F_ALM1, i_alarm_first)
               | one_bit(sds_pkg::F_ALM2, i_alarm_second);

   // a set in the clearing cycle survives the clear
   assign sets = (tick ? cond : 16'h0000)
               | one_bit(sds_pkg::F_SPI, frame_err)
               | one_bit(sds_pkg::F_SELF, i_selftest_done && i_selftest_fail);

   assign clrs = one_bit(sds_pkg::F_SUPPLY, !i_supply_low)
               | one_bit(sds_pkg::F_SELF, i_selftest_done && !i_selftest_fail);

   assign wbus.tx_word = st.tx;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st       = st;
      next_st.cs_q  = cs_s;
      next_st.tog_q = tog_s;
      next_st.flags = (((rd_flags ? sds_pkg::FLAGS_RESET : st.flags) & ~clrs) | sets)
                    & sds_pkg::FLAGS_USED;
      if (is_rd)
         next_st.tx = reg_read(addr, st.flags, st.sleep);
      unique case (st.pwr)
         ST_AWAKE:
         begin
            if (wr_sleep)
            begin
               next_st.sleep = data;
               if (data == sds_pkg::SLEEP_FOREVER)
                  next_st.pwr = ST_HOLD;
               else if (data != sds_pkg::SLEEP_NONE)
               begin
                  next_st.pwr    = ST_TIMED;
                  next_st.halves = data - 8'h01;
                  next_st.sub    = HALF_SEC_CYCLES - 32'h1;
               end
            end
         end
         ST_TIMED:
         begin
            if (cs_fall)
               next_st.pwr = ST_AWAKE;
            else if (st.sub != 32'h0)
               next_st.sub = st.sub - 32'h1;
            else if (st.halves == 8'h00)
               next_st.pwr = ST_AWAKE;
            else
            begin
               next_st.halves = st.halves - 8'h01;
               next_st.sub    = HALF_SEC_CYCLES - 32'h1;
            end
         end
         ST_HOLD:
         begin
            if (cs_fall)
               next_st.pwr = ST_AWAKE;
         end
      endcase
      next_st.run = next_st.pwr == ST_AWAKE;
   end

   // reset line wakes the part as well
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         st <= '{pwr: ST_AWAKE, run: 1'b1, sleep: sds_pkg::SLEEP_RESET, sub: 32'h0,
                 halves: 8'h00, flags: sds_pkg::FLAGS_RESET, tx: 16'h0000,
                 cs_q: 1'b1, tog_q: 1'b0};
      else
         st <= next_st;
   end

   assign o_sample_run = st.run;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_hold_sleep;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st.run && wr_sleep && data == sds_pkg::SLEEP_FOREVER && !cs_fall)
         |=> !o_sample_run ##1 (!o_sample_run || $past(cs_fall));
   endproperty
   a_hold_sleep: assert property (p_hold_sleep) else $error("hold sleep not entered");

   property p_wake_cs;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!st.run && cs_fall) |=> o_sample_run;
   endproperty
   a_wake_cs: assert property (p_wake_cs) else $error("chip select did not wake");

   property p_timed_end;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st.pwr == ST_TIMED && st.sub == 32'h0 && st.halves == 8'h00) |=> o_sample_run;
   endproperty
   a_timed_end: assert property (p_timed_end) else $error("timed sleep did not end");

   property p_timed_count;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st.pwr == ST_TIMED && st.sub != 32'h0 && !cs_fall)
         |=> st.pwr == ST_TIMED && st.sub == $past(st.sub) - 32'h1;
   endproperty
   a_timed_count: assert property (p_timed_count) else $error("sleep timer stalled");

   property p_read_snap;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_flags |=> st.tx == $past(st.flags);
   endproperty
   a_read_snap: assert property (p_read_snap) else $error("flag read lost value");

   property p_read_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_flags && !tick && !frame_err && !i_selftest_done) |=> st.flags == 16'h0000;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("flags not cleared");

   property p_resample;
      @(posedge i_clk) disable iff (!i_rst_n)
      (tick && i_over_range) |=> st.flags[sds_pkg::F_RANGE];
   endproperty
   a_resample: assert property (p_resample) else $error("range flag not set");

   property p_supply_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      !i_supply_low |=> !st.flags[sds_pkg::F_SUPPLY];
   endproperty
   a_supply_clear: assert property (p_supply_clear) else $error("supply flag stuck");

   property p_frame_err;
      @(posedge i_clk) disable iff (!i_rst_n)
      frame_err |=> st.flags[sds_pkg::F_SPI];
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("frame error missed");

   property p_unused;
      @(posedge i_clk) disable iff (!i_rst_n)
      (st.flags & ~sds_pkg::FLAGS_USED) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused flag bit set");

   property p_selftest;
      @(posedge i_clk) disable iff (!i_rst_n)
      i_selftest_done |=> st.flags[sds_pkg::F_SELF] == $past(i_selftest_fail);
   endproperty
   a_selftest: assert property (p_selftest) else $error("self-test result lost");

   property p_no_sample;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!st.run && !rd_flags && !frame_err && !i_selftest_done)
         |=> (st.flags & ~one_bit(sds_pkg::F_SUPPLY, 1'b1))
             == ($past(st.flags) & ~one_bit(sds_pkg::F_SUPPLY, 1'b1));
   endproperty
   a_no_sample: assert property (p_no_sample) else $error("flags moved in sleep");

   property p_cov_timed;
      @(posedge i_clk) disable iff (!i_rst_n)
      st.pwr == ST_TIMED ##1 st.pwr == ST_AWAKE;
   endproperty
   c_cov_timed: cover property (p_cov_timed);

   property p_cov_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      st.pwr == ST_HOLD ##1 st.pwr == ST_AWAKE;
   endproperty
   c_cov_hold: cover property (p_cov_hold);

   property p_cov_frame;
      @(posedge i_clk) disable iff (!i_rst_n)
      frame_err;
   endproperty
   c_cov_frame: cover property (p_cov_frame);

   property p_cov_selfclr;
      @(posedge i_clk) disable iff (!i_rst_n)
      st.flags[sds_pkg::F_SELF] && i_selftest_done && !i_selftest_fail;
   endproperty
   c_cov_selfclr: cover property (p_cov_selfclr);
endmodule : sleep_and_diagnostic_status

// [verif/spi_host_model.sv]
// host model: spi master in mode 3 that frames 16-bit words
`timescale 1ns/10ps
module spi_host_model
(
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi,
   input  wire logic i_miso
);
   initial
   begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_mosi = 1'b1;
   end
   // ----------------------------------------------------------------
   // shifter: mosi moves on falling sclk, miso taken on rising sclk
   // ----------------------------------------------------------------
   task automatic shift(input int n, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         #40 o_sclk = 1'b0;
         o_mosi = tx[15-i];
         #40 o_sclk = 1'b1;
         rx = {rx[14:0], i_miso};
      end
   endtask : shift
   // ----------------------------------------------------------------
   // one select frame of up to two words; n0 below 16 breaks it
   // ----------------------------------------------------------------
   task automatic frame(input int n0, input logic [15:0] w0, input int n1,
                        input logic [15:0] w1, output logic [15:0] r1);
      logic [15:0] r0;
      r1 = 16'h0000;
      #7 o_cs_n = 1'b0;
      shift(n0, w0, r0);
      if (n1 > 0)
         shift(n1, w1, r1);
      #40 o_cs_n = 1'b1;
      // released line has no pull, so show the opposite level
      o_mosi = ~o_mosi;
      // gap well above the three core cycles the select sync needs
      #200;
   endtask : frame
endmodule : spi_host_model

// [verif/testbench.sv]
// self-checking bench for the sleep and status register block
`timescale 1ns/10ps
module testbench;
   localparam int HALF = 100;
   logic        i_clk;
   logic        i_rst_n;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic        miso_oe;
   logic        tick;
   logic        st_done;
   logic        st_fail;
   logic        run;
   logic [5:0]  cond;
   logic [15:0] rd;
   int          bad_count;
   int          num_checks;
   int          tmo = 0;
   time         t0;
   int          bit_of [6] = '{sds_pkg::F_SUPPLY, sds_pkg::F_FLASH, sds_pkg::F_RANGE,
                               sds_pkg::F_CSUM, sds_pkg::F_ALM1, sds_pkg::F_ALM2};
   logic [6:0]  id_addr [6] = '{sds_pkg::ADDR_LOT_FIRST, sds_pkg::ADDR_LOT_SECOND,
                                sds_pkg::ADDR_LOT_THIRD, sds_pkg::ADDR_PRODUCT,
                                sds_pkg::ADDR_SERIAL, 7'h28};
   // identity values are arbitrary
   logic [15:0] id_val [6] = '{16'h1a2b, 16'h3c4d, 16'h5e6f, 16'h0c0d, 16'h270f, 16'h0000};

   sleep_and_diagnostic_status
   #(
      .HALF_SEC_CYCLES (32'(HALF)),
      .LOT_FIRST       (16'h1a2b),
      .LOT_SECOND      (16'h3c4d),
      .LOT_THIRD       (16'h5e6f),
      .SERIAL_NUMBER   (14'h270f),
      .PRODUCT_CODE    (16'h0c0d)
   )
   dut
   (
      .i_clk           (i_clk),
      .i_rst_n         (i_rst_n),
      .i_sclk          (sclk),
      .i_cs_n          (cs_n),
      .i_mosi          (mosi),
      .o_miso          (miso),
      .o_miso_oe       (miso_oe),
      .i_sample_tick   (tick),
      .i_supply_low    (cond[0]),
      .i_flash_fail    (cond[1]),
      .i_over_range    (cond[2]),
      .i_checksum_fail (cond[3]),
      .i_alarm_first   (cond[4]),
      .i_alarm_second  (cond[5]),
      .i_selftest_done (st_done),
      .i_selftest_fail (st_fail),
      .o_sample_run    (run)
   );

   spi_host_model host
   (
      .o_sclk (sclk),
      .o_cs_n (cs_n),
      .o_mosi (mosi),
      .i_miso (miso)
   );

   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic results();
      if (bad_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic check16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask : check16

   task automatic check1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: level %b, wanted %b", $time, got, exp);
      end
   endtask : check1

   task automatic wait_clk(input int n);
      repeat (n) @(posedge i_clk);
   endtask : wait_clk

   // answer comes back in the second word of the same frame
   task automatic reg_read(input logic [6:0] addr, output logic [15:0] data);
      host.frame(16, {1'b0, addr, 8'h00}, 16, 16'h0000, data);
      check1(miso_oe, 1'b0);
   endtask : reg_read

   task automatic reg_write(input logic [6:0] addr, input logic [7:0] data);
      host.frame(16, {1'b1, addr, data}, 0, 16'h0000, rd);
   endtask : reg_write

   task automatic tick_pulse();
      @(posedge i_clk) tick <= 1'b1;
      @(posedge i_clk) tick <= 1'b0;
      wait_clk(2);
   endtask : tick_pulse

   initial
   begin
      forever
      begin
         @(posedge i_clk);
         tmo++;
         if (tmo == 60000)
         begin
            bad_count++;
            results();
         end
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      i_rst_n = 1'b0;
      tick = 1'b0;
      st_done = 1'b0;
      st_fail = 1'b0;
      cond = 6'h00;
      bad_count = 0;
      num_checks = 0;
      wait_clk(4);
      i_rst_n <= 1'b1;
      wait_clk(3);
      check1(run, 1'b1);
      reg_read(sds_pkg::ADDR_FLAGS, rd);
      check16(rd, sds_pkg::FLAGS_RESET);
      reg_write(sds_pkg::ADDR_PRODUCT, 8'hff);
      for (int i = 0; i < 6; i++)
      begin
         reg_read(id_addr[i], rd);
         check16(rd, id_val[i]);
      end
      for (int i = 0; i < 6; i++)
      begin
         @(posedge i_clk) cond[i] <= 1'b1;
         tick_pulse();
         reg_read(sds_pkg::ADDR_FLAGS, rd);
         check16(rd, 16'h0001 << bit_of[i]);
         reg_read(sds_pkg::ADDR_FLAGS, rd);
         check16(rd, 16'h0000);
         tick_pulse();
         reg_read(sds_pkg::ADDR_FLAGS, rd);
         check16(rd, 16'h0001 << bit_of[i]);
         tick_pulse();
         @(posedge i_clk) cond[i] <= 1'b0;
         wait_clk(3);
         reg_read(sds_pkg::ADDR_FLAGS, rd);
         check16(rd, (i == 0) ? 16'h0000 : 16'h0001 << bit_of[i]);
      end
      for (int f = 1; f >= 0; f--)
      begin
         // a failing result first, so a pass has a set flag to clear
         @(posedge i_clk)
         begin
            st_done <= 1'b1;
            st_fail <= 1'b1;
         end
         @(posedge i_clk) st_fail <= f[0];
         @(posedge i_clk) st_done <= 1'b0;
         reg_read(sds_pkg::ADDR_FLAGS, rd);
         check16(rd, {10'h000, f[0], 5'h00});
      end
      // half a word ends the frame mid-count, which sets the frame flag
      host.frame(8, 16'hffff, 0, 16'h0000, rd);
      wait_clk(5);
      reg_read(sds_pkg::ADDR_FLAGS, rd);
      check16(rd, 16'h0008);
      reg_read(sds_pkg::ADDR_FLAGS, rd);
      check16(rd, 16'h0000);
      // ----------------------------------------------------------------
      // sleep modes
      // ----------------------------------------------------------------
      reg_write(sds_pkg::ADDR_SLEEP, 8'h03);
      t0 = $time;
      check1(run, 1'b0);
      @(posedge i_clk) cond[2] <= 1'b1;
      tick_pulse();
      @(posedge i_clk) cond[2] <= 1'b0;
      // looked at mid-cycle, away from the edge that launches it
      for (int n = 0; n < 1000 && run !== 1'b1; n++)
         @(negedge i_clk);
      // frame tail is 60 clocks after the word is taken
      check1(($time - t0) / 4 >= 3 * HALF - 64 && ($time - t0) / 4 <= 3 * HALF - 48,
             1'b1);
      reg_read(sds_pkg::ADDR_FLAGS, rd);
      check16(rd, 16'h0000);
      reg_read(sds_pkg::ADDR_SLEEP, rd);
      check16(rd, 16'h0003);
      reg_write(sds_pkg::ADDR_SLEEP, sds_pkg::SLEEP_FOREVER);
      wait_clk(1000);
      check1(run, 1'b0);
      reg_read(sds_pkg::ADDR_SLEEP, rd);
      check16(rd, {8'h00, sds_pkg::SLEEP_FOREVER});
      check1(run, 1'b1);
      reg_write(sds_pkg::ADDR_SLEEP, sds_pkg::SLEEP_FOREVER);
      check1(run, 1'b0);
      @(posedge i_clk) i_rst_n <= 1'b0;
      wait_clk(3);
      i_rst_n <= 1'b1;
      wait_clk(3);
      check1(run, 1'b1);
      reg_read(sds_pkg::ADDR_SLEEP, rd);
      check16(rd, 16'h0000);
      reg_write(sds_pkg::ADDR_SLEEP, sds_pkg::SLEEP_NONE);
      check1(run, 1'b1);
      results();
   end
endmodule : testbench
